/* bench/lcdio_pin_model.sv */
// Behavioural model of the external pins and their loads.
`timescale 1ns/1ps
module lcdio_pin_model (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_pin_out,
  input  wire logic [23:0] i_oe_n,
  input  wire logic [23:0] i_pullup,
  input  wire logic [23:0] i_ext_val,
  input  wire logic [23:0] i_ext_drive,
  output logic      [23:0] o_level
);
  logic [23:0] last;
  always_ff @(posedge i_clk) last <= o_level;
  // A floating unpulled pin toggles so a stale level never passes for a real one.
  always_comb begin
    for (int b = 0; b < 24; b++) begin
      if (!i_oe_n[b]) o_level[b] = i_pin_out[b];
      else if (i_ext_drive[b]) o_level[b] = i_ext_val[b];
      else if (i_pullup[b]) o_level[b] = 1'b1;
      else o_level[b] = ~last[b];
    end
  end
endmodule

/* bench/lcdio_ports_sva.sv */
// Checker for the shared LCD port block.
`timescale 1ns/1ps
module lcdio_ports_sva (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic [3:0]  i_segment_select_field,
  input wire logic [2:0]  i_power_mode,
  input wire logic [23:0] i_segment_output,
  input wire logic [23:0] o_pin,
  input wire logic [23:0] o_pin_oe_n,
  input wire logic [23:0] o_pullup_on,
  input wire logic [7:0]  o_wake_n
);
  logic [23:0] mask_q, seg_q, mask;
  logic        live_q;
  function automatic logic [23:0] seg_mask(input logic [3:0] s);
    return {{4{s inside {[6:13]}}}, {4{s inside {[5:12]}}}, {4{s inside {[4:11]}}},
            {4{s inside {[3:10]}}}, {4{s inside {[2:9]}}}, {4{s inside {[1:8]}}}};
  endfunction
  assign mask = seg_mask(i_segment_select_field);
  always_ff @(posedge i_clk) begin
    mask_q <= mask;
    seg_q  <= i_segment_output;
    live_q <= !i_reset && i_power_mode <= 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_seg_pin_drive: assert property (live_q |-> (o_pin_oe_n & mask_q) == 24'h00_0000
    && ((o_pin ^ seg_q) & mask_q) == 24'h00_0000) else $error("segment pin not following waveform");
  a_seg_no_pullup: assert property ((o_pullup_on & (mask | 24'hFF_0000)) == 24'h00_0000)
    else $error("pull-up on a segment or third-port pin");
  a_seg_no_wake: assert property (({16'h0000, ~o_wake_n} & mask) == 24'h00_0000)
    else $error("wake level on a segment pin");
  a_reset_float: assert property ($fell(i_reset) |-> o_pin_oe_n == 24'hFF_FFFF && o_pullup_on == 24'h00_0000)
    else $error("pins not floating after reset");
  a_standby_float: assert property ($past(i_power_mode) == 3'h5 && !$past(i_reset) |-> o_pin_oe_n == 24'hFF_FFFF)
    else $error("pin driven in standby");
  a_sleep_hold: assert property ($past(i_power_mode) inside {3'h2, 3'h3, 3'h4} && !$past(i_reset)
    |-> $stable(o_pin) && $stable(o_pin_oe_n)) else $error("pin changed in a holding mode");
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("access not answered after one wait state");
  a_wait_idle: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("wait asserted without a request");
endmodule
bind lcdio_ports lcdio_ports_sva u_sva (.i_clk, .i_reset, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .i_segment_select_field, .i_power_mode, .i_segment_output, .o_pin, .o_pin_oe_n, .o_pullup_on, .o_wake_n);

/* bench/tb_lcdio_ports.sv */
// Self-checking bench for the shared LCD port block.
`timescale 1ns/1ps
`include "lcdio_map.svh"
module tb_lcdio_ports;
  logic        i_clk = 1'b0, i_reset = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest;
  logic [17:0] i_avs_address = 18'h0_0000;
  logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata;
  logic [3:0]  i_avs_byteenable = 4'hF, sel = 4'h0;
  logic [2:0]  mode = 3'h0;
  logic [23:0] segment_output = 24'h5A_C396, ext_val = 24'h3C_69A2, ext_en = 24'hFF_FFFF;
  logic [23:0] i_pin, o_pin, o_pin_oe_n, o_pullup_on, m;
  logic [7:0]  o_wake_n, rd;
  int          error_cnt = 0, comparisons = 0;
  always #20 i_clk = ~i_clk;
  lcdio_ports uut (.i_clk, .i_reset, .i_clk_en(1'b1), .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_segment_select_field(sel), .i_power_mode(mode),
    .i_segment_output(segment_output), .i_pin, .o_pin, .o_pin_oe_n, .o_pullup_on, .o_wake_n);
  lcdio_pin_model u_pins (.i_clk, .i_pin_out(o_pin), .i_oe_n(o_pin_oe_n), .i_pullup(o_pullup_on),
    .i_ext_val(ext_val), .i_ext_drive(ext_en & o_pin_oe_n), .o_level(i_pin));
  task automatic cmp(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h00_0000, d};
    i_avs_write <= wr;
    i_avs_read <= !wr;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
    rd = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    cmp(rd, exp);
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    cmp(o_pin_oe_n, 24'hFF_FFFF);
    cmp(o_pullup_on, 24'h00_0000);
    rdchk(`LCDIO_IDX_P6_DIR, 8'hFF);
    rdchk(`LCDIO_IDX_P7_DIR, 8'hFF);
    rdchk(`LCDIO_IDX_P5_DIR, 8'hFF);
    rdchk(`LCDIO_IDX_P6_PULLUP, 8'h00);
    rdchk(`LCDIO_IDX_P5_FUNC, 8'h00);
    rdchk(16'hFFF0, 8'h00);
    for (int p = 0; p < 3; p++) begin
      acc(1'b1, `LCDIO_IDX_P5_DIR + p, 8'hF0);
      rdchk(`LCDIO_IDX_P5_DATA + p, {4'h0, ext_val[8*p +: 4]});
      acc(1'b1, `LCDIO_IDX_P5_DATA + p, 8'hA5);
      rdchk(`LCDIO_IDX_P5_DATA + p, {4'hA, ext_val[8*p +: 4]});
      @(negedge i_clk);
      cmp(o_pin_oe_n[8*p +: 8], 8'h0F);
      cmp(o_pin[8*p +: 8] & 8'hF0, 8'hA0);
    end
    acc(1'b1, `LCDIO_IDX_P6_PULLUP, 8'hFF);
    acc(1'b1, `LCDIO_IDX_P5_PULLUP, 8'h3C);
    acc(1'b1, `LCDIO_IDX_P5_DIR, 8'hF3);
    acc(1'b1, `LCDIO_IDX_P5_FUNC, 8'h03);
    @(posedge i_clk);
    i_avs_byteenable <= 4'h0;
    acc(1'b1, `LCDIO_IDX_P6_PULLUP, 8'h00);
    @(posedge i_clk);
    i_avs_byteenable <= 4'hF;
    rdchk(`LCDIO_IDX_P6_PULLUP, 8'hFF);
    @(negedge i_clk);
    cmp(o_pullup_on, 24'h00_0F0C);
    cmp(o_pin_oe_n, 24'h0F_0F0F);
    cmp(o_wake_n, 8'hFE);
    for (int s = 0; s < 16; s++) begin
      @(posedge i_clk);
      sel <= s[3:0];
      repeat (2) @(negedge i_clk);
      m = {{4{s inside {[6:13]}}}, {4{s inside {[5:12]}}}, {4{s inside {[4:11]}}},
           {4{s inside {[3:10]}}}, {4{s inside {[2:9]}}}, {4{s inside {[1:8]}}}};
      cmp(o_pin_oe_n, 24'h0F_0F0F & ~m);
      cmp(o_pin & m, segment_output & m);
      cmp(o_wake_n, 8'hFE | m[7:0]);
    end
    for (int k = 2; k < 5; k++) begin
      @(posedge i_clk);
      mode <= k[2:0];
      acc(1'b1, `LCDIO_IDX_P7_DATA, 8'h50);
      @(negedge i_clk);
      cmp(o_pin[23:20], 4'hA);
      @(posedge i_clk);
      mode <= 3'h1;
      repeat (2) @(negedge i_clk);
      cmp(o_pin[23:20], 4'h5);
      acc(1'b1, `LCDIO_IDX_P7_DATA, 8'hA5);
    end
    @(posedge i_clk);
    mode <= 3'h5;
    ext_en <= 24'h00_0000;
    repeat (2) @(negedge i_clk);
    cmp(o_pin_oe_n, 24'hFF_FFFF);
    cmp(o_pullup_on, 24'h00_0F0C);
    cmp(i_pin[15:8] & 8'h0F, 8'h0F);
    report_and_stop();
  end
endmodule

/* shared/lcdio_map.svh */
// Register indices, address width, reset values and segment ranges of the shared LCD ports.
`ifndef LCDIO_MAP_SVH
`define LCDIO_MAP_SVH

`define LCDIO_IDX_P5_DATA    16'hFFD8
`define LCDIO_IDX_P6_DATA    16'hFFD9
`define LCDIO_IDX_P7_DATA    16'hFFDA
`define LCDIO_IDX_P5_PULLUP  16'hFFE2
`define LCDIO_IDX_P6_PULLUP  16'hFFE3
`define LCDIO_IDX_P5_DIR     16'hFFE8
`define LCDIO_IDX_P6_DIR     16'hFFE9
`define LCDIO_IDX_P7_DIR     16'hFFEA
`define LCDIO_IDX_P5_FUNC    16'hFFCC

`define LCDIO_ADDR_W         18
`define LCDIO_REG_RESET      8'h00
`define LCDIO_WO_READ        8'hFF

`define LCDIO_P5_HI_LO       4'h2
`define LCDIO_P5_HI_HI       4'h9
`define LCDIO_P5_LO_LO       4'h1
`define LCDIO_P5_LO_HI       4'h8
`define LCDIO_P6_HI_LO       4'h4
`define LCDIO_P6_HI_HI       4'hB
`define LCDIO_P6_LO_LO       4'h3
`define LCDIO_P6_LO_HI       4'hA
`define LCDIO_P7_HI_LO       4'h6
`define LCDIO_P7_HI_HI       4'hD
`define LCDIO_P7_LO_LO       4'h5
`define LCDIO_P7_LO_HI       4'hC

`endif

/* shared/lcdio_pkg.sv */
// Types shared by the shared LCD port block.
package lcdio_pkg;
  typedef enum logic [2:0] {
    LCDIO_ACTIVE    = 3'h0,
    LCDIO_SUBACTIVE = 3'h1,
    LCDIO_SLEEP     = 3'h2,
    LCDIO_SUBSLEEP  = 3'h3,
    LCDIO_WATCH     = 3'h4,
    LCDIO_STANDBY   = 3'h5
  } lcdio_mode_t;
endpackage

/* verilog/lcdio_ports.sv */
// Three 8-bit I/O ports sharing pins with LCD segment outputs, with an Avalon-MM register slave.
//
// Contract
// - Wake bit makes first-port pin active-low input.
// - First port upper half segments for 0010-1001.
// - First port lower half segments for 0001-1000.
// - Second port upper half segments for 0100-1011.
// - Second port lower half segments for 0011-1010.
// - Third port upper half segments for 0110-1101.
// - Third port lower half segments for 0101-1100.
// - Second port direction bit one means output.
// - Third port direction bit one means output.
// - Second port data read: latch or pin.
// - Third port data read: latch or pin.
// - Second, third direction registers read all ones.
// - Latch and direction only act on general pins.
// - Second port registers reset to zero.
// - Third port registers reset to zero.
// - Second port pull-up only for pulled-up inputs.
// - First port pull-up only for pulled-up inputs.
// - Pull-ups of first and second off after reset.
// - Float in reset/standby, hold in sleep modes.
// - Pulled-up pins show high in standby.
// - First port data read: latch or pin.
// - First port direction reads ones; registers reset zero.
`timescale 1ns/1ps
`include "lcdio_map.svh"

module lcdio_ports (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_clk_en,
  input  wire logic [`LCDIO_ADDR_W-1:0]      i_avs_address,
  input  wire logic                          i_avs_read,
  input  wire logic                          i_avs_write,
  input  wire logic [31:0]                   i_avs_writedata,
  input  wire logic [3:0]                    i_avs_byteenable,
  output logic      [31:0]                   o_avs_readdata,
  output logic                               o_avs_waitrequest,
  input  wire logic [3:0]                    i_segment_select_field,
  input  wire logic [2:0]                    i_power_mode,
  input  wire logic [23:0]                   i_segment_output,
  input  wire logic [23:0]                   i_pin,
  output logic      [23:0]                   o_pin,
  output logic      [23:0]                   o_pin_oe_n,
  output logic      [23:0]                   o_pullup_on,
  output logic      [7:0]                    o_wake_n
);

  // Register state: index 0 is the first port, 1 the second, 2 the third.
  logic [7:0]  port_data      [3];
  logic [7:0]  port_direction [3];
  logic [7:0]  port_pullup    [2];
  logic [7:0]  wake_select;
  logic [7:0]  next_port_data      [3];
  logic [7:0]  next_port_direction [3];
  logic [7:0]  next_port_pullup    [2];
  logic [7:0]  next_wake_select;

  // Bus handshake state.
  logic        ack;
  logic [7:0]  readdata;
  logic        next_ack;
  logic [7:0]  next_readdata;

  // Pin state, registered so retention modes can hold it.
  logic [23:0] pin_out;
  logic [23:0] pin_drive;
  logic [23:0] next_pin_out;
  logic [23:0] next_pin_drive;

  // Combinational per-pin decisions.
  logic [23:0] seg_sel;
  logic [23:0] gp_drive;
  logic [23:0] live_level;
  logic [23:0] pull_req;
  logic [7:0]  pin_read [3];

  lcdio_pkg::lcdio_mode_t mode;

  function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] lvl);
    port_read = (latch & dir) | (lvl & ~dir);
  endfunction

  assign mode = lcdio_pkg::lcdio_mode_t'(i_power_mode);

  // Segment assignment per half port, four pins each.
  always_comb begin
    seg_sel[7:4]   = {4{in_range(i_segment_select_field, `LCDIO_P5_HI_LO, `LCDIO_P5_HI_HI)}};
    seg_sel[3:0]   = {4{in_range(i_segment_select_field, `LCDIO_P5_LO_LO, `LCDIO_P5_LO_HI)}};
    seg_sel[15:12] = {4{in_range(i_segment_select_field, `LCDIO_P6_HI_LO, `LCDIO_P6_HI_HI)}};
    seg_sel[11:8]  = {4{in_range(i_segment_select_field, `LCDIO_P6_LO_LO, `LCDIO_P6_LO_HI)}};
    seg_sel[23:20] = {4{in_range(i_segment_select_field, `LCDIO_P7_HI_LO, `LCDIO_P7_HI_HI)}};
    seg_sel[19:16] = {4{in_range(i_segment_select_field, `LCDIO_P7_LO_LO, `LCDIO_P7_LO_HI)}};
  end

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_port
      // A wake input never drives, whatever its direction bit says.
      if (gp == 0) begin : g_wake
        assign gp_drive[7:0] = port_direction[0] & ~wake_select;
      end else begin : g_plain
        assign gp_drive[gp*8 +: 8] = port_direction[gp];
      end
      // Pull-ups exist on the first two ports and only on input pins.
      if (gp < 2) begin : g_pull
        assign pull_req[gp*8 +: 8] = port_pullup[gp] & ~port_direction[gp];
      end else begin : g_nopull
        assign pull_req[gp*8 +: 8] = 8'h00;
      end
      assign live_level[gp*8 +: 8] = i_pin[gp*8 +: 8];
      assign pin_read[gp] = port_read(port_data[gp], port_direction[gp], live_level[gp*8 +: 8]);
    end
  endgenerate

  // Pin state: functional modes update, sleep-type modes hold, reset and standby float.
  always_comb begin
    next_pin_out   = pin_out;
    next_pin_drive = pin_drive;
    unique case (mode)
      lcdio_pkg::LCDIO_ACTIVE, lcdio_pkg::LCDIO_SUBACTIVE: begin
        for (int i = 0; i < 24; i++) begin
          if (seg_sel[i]) begin
            next_pin_out[i]   = i_segment_output[i];
            next_pin_drive[i] = 1'b1;
          end else begin
            next_pin_out[i]   = port_data[i / 8][i % 8];
            next_pin_drive[i] = gp_drive[i];
          end
        end
      end
      lcdio_pkg::LCDIO_SLEEP, lcdio_pkg::LCDIO_SUBSLEEP, lcdio_pkg::LCDIO_WATCH: begin
        next_pin_out   = pin_out;
        next_pin_drive = pin_drive;
      end
      lcdio_pkg::LCDIO_STANDBY: begin
        next_pin_out   = 24'h00_0000;
        next_pin_drive = 24'h00_0000;
      end
      default: begin
        next_pin_out   = 24'h00_0000;
        next_pin_drive = 24'h00_0000;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_out   <= 24'h00_0000;
      pin_drive <= 24'h00_0000;
    end else if (i_clk_en) begin
      pin_out   <= next_pin_out;
      pin_drive <= next_pin_drive;
    end
  end

  // A pulled-up input keeps its pull-up in standby so the pin shows high.
  always_comb begin
    o_pin       = pin_out;
    o_pin_oe_n  = ~pin_drive;
    o_pullup_on = pull_req & ~pin_drive & ~seg_sel;
    o_wake_n    = i_pin[7:0] | ~wake_select | seg_sel[7:0];
  end

  // Register file: one wait state, then the access completes with waitrequest low.
  always_comb begin
    logic       wr;
    logic [7:0] wd;
    wr = i_avs_write && ack && i_avs_byteenable[0];
    wd = i_avs_writedata[7:0];
    next_ack = (i_avs_read || i_avs_write) && !ack;
    next_readdata = readdata;
    for (int p = 0; p < 3; p++) begin
      next_port_data[p]      = port_data[p];
      next_port_direction[p] = port_direction[p];
    end
    for (int p = 0; p < 2; p++) begin
      next_port_pullup[p] = port_pullup[p];
    end
    next_wake_select = wake_select;
    if (i_avs_read && !ack) begin
      unique case (i_avs_address)
        {`LCDIO_IDX_P5_DATA, 2'b00}:   next_readdata = pin_read[0];
        {`LCDIO_IDX_P6_DATA, 2'b00}:   next_readdata = pin_read[1];
        {`LCDIO_IDX_P7_DATA, 2'b00}:   next_readdata = pin_read[2];
        {`LCDIO_IDX_P5_PULLUP, 2'b00}: next_readdata = port_pullup[0];
        {`LCDIO_IDX_P6_PULLUP, 2'b00}: next_readdata = port_pullup[1];
        {`LCDIO_IDX_P5_DIR, 2'b00}:    next_readdata = `LCDIO_WO_READ;
        {`LCDIO_IDX_P6_DIR, 2'b00}:    next_readdata = `LCDIO_WO_READ;
        {`LCDIO_IDX_P7_DIR, 2'b00}:    next_readdata = `LCDIO_WO_READ;
        {`LCDIO_IDX_P5_FUNC, 2'b00}:   next_readdata = wake_select;
        default:                       next_readdata = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (i_avs_address)
        {`LCDIO_IDX_P5_DATA, 2'b00}:   next_port_data[0] = wd;
        {`LCDIO_IDX_P6_DATA, 2'b00}:   next_port_data[1] = wd;
        {`LCDIO_IDX_P7_DATA, 2'b00}:   next_port_data[2] = wd;
        {`LCDIO_IDX_P5_PULLUP, 2'b00}: next_port_pullup[0] = wd;
        {`LCDIO_IDX_P6_PULLUP, 2'b00}: next_port_pullup[1] = wd;
        {`LCDIO_IDX_P5_DIR, 2'b00}:    next_port_direction[0] = wd;
        {`LCDIO_IDX_P6_DIR, 2'b00}:    next_port_direction[1] = wd;
        {`LCDIO_IDX_P7_DIR, 2'b00}:    next_port_direction[2] = wd;
        {`LCDIO_IDX_P5_FUNC, 2'b00}:   next_wake_select = wd;
        default:                       next_wake_select = wake_select;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int p = 0; p < 3; p++) begin
        port_data[p]      <= `LCDIO_REG_RESET;
        port_direction[p] <= `LCDIO_REG_RESET;
      end
      for (int p = 0; p < 2; p++) begin
        port_pullup[p] <= `LCDIO_REG_RESET;
      end
      wake_select <= `LCDIO_REG_RESET;
      ack         <= 1'b0;
      readdata    <= 8'h00;
    end else if (i_clk_en) begin
      port_data      <= next_port_data;
      port_direction <= next_port_direction;
      port_pullup    <= next_port_pullup;
      wake_select    <= next_wake_select;
      ack            <= next_ack;
      readdata       <= next_readdata;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
  assign o_avs_readdata    = {24'h00_0000, readdata};

endmodule
